//--- src/pdrs_ctrl.sv
`timescale 1ns/1ns
// What this block does
// RULE_01 - rate converter off while its bit is 0
// RULE_02 - receiver off, outputs low while bit 0
// RULE_03 - transmitter off, outputs low while bit 0
// RULE_04 - port B off, outputs low while bit 0
// RULE_05 - port A off, outputs low while bit 0
// RULE_06 - global bit 0 powers down every block
// RULE_07 - writing reset bit equals external reset
// RULE_08 - soft reset restores defaults, bit reads 0
// RULE_09 - summary bit 0 flags rate converter interrupt
// RULE_10 - summary bit 1 flags receiver interrupt
// RULE_11 - summary bit 2 flags transmitter interrupt
// RULE_12 - summary bits OR sources; unused bits zero
module pdrs_ctrl
    import pdrs_pkg::*;
#(
    parameter int RX_OUT_W = 8,
    parameter int TX_OUT_W = 4,
    parameter int PA_OUT_W = 3,
    parameter int PB_OUT_W = 3
)
(
    // clock and external reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register access from the host port decoder
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    // unmasked interrupt sources of each block
    input wire logic [PDRS_RC_SRC_W-1:0] rate_conv_irq_src,
    input wire logic [PDRS_RX_SRC_W-1:0] receiver_irq_src,
    input wire logic [PDRS_TX_SRC_W-1:0] transmitter_irq_src,
    // block run enables
    output logic rate_conv_run,
    output logic receiver_run,
    output logic transmitter_run,
    output logic serial_port_a_run,
    output logic serial_port_b_run,
    output logic all_blocks_run,
    // reset to every control register of the device
    output logic ctrl_rst_n,
    // raw and gated block outputs
    input wire logic [RX_OUT_W-1:0] receiver_raw,
    input wire logic [TX_OUT_W-1:0] transmitter_raw,
    input wire logic [PA_OUT_W-1:0] serial_port_a_raw,
    input wire logic [PB_OUT_W-1:0] serial_port_b_raw,
    output logic [RX_OUT_W-1:0] receiver_out,
    output logic [TX_OUT_W-1:0] transmitter_out,
    output logic [PA_OUT_W-1:0] serial_port_a_out,
    output logic [PB_OUT_W-1:0] serial_port_b_out
);

    // every gated block needs at least one output line
    if (RX_OUT_W < 1 || TX_OUT_W < 1 || PA_OUT_W < 1 || PB_OUT_W < 1)
    begin : g_bad_width
        $error("pdrs_ctrl: output widths must be at least 1");
    end

    typedef struct packed {
        logic [7:0] pwr;
        logic [2:0] srst_cnt;
        logic [PDRS_IRQ_NBITS-1:0] irq;
        logic [7:0] rdata;
        logic hit;
    } pdrs_ctrl_s;

    pdrs_ctrl_s state_reg;
    pdrs_ctrl_s state_next;

    logic srst_active;
    logic [PDRS_IRQ_NBITS-1:0] irq_now;

    // soft reset pulse holds for a few cycles so every block sees it
    assign srst_active = (state_reg.srst_cnt != 3'h0);

    // summary is the OR of each block's sources
    always_comb
    begin
        irq_now = '0;
        irq_now[PDRS_IRQ_RATE_CONV] = |rate_conv_irq_src; // see RULE_09
        irq_now[PDRS_IRQ_RECEIVER] = |receiver_irq_src; // see RULE_10
        irq_now[PDRS_IRQ_TRANSMITTER] = |transmitter_irq_src; // see RULE_11
    end

    // =========================================================
    // register file and soft reset sequencer
    always_comb
    begin
        state_next = state_reg;
        state_next.irq = irq_now; // see RULE_12
        state_next.hit = 1'b0;
        state_next.rdata = 8'h00;
        if (srst_active)
        begin
            // defaults restored and held for the whole sequence
            state_next.srst_cnt = state_reg.srst_cnt - 3'h1;
            state_next.pwr = PDRS_PWR_RESET; // see RULE_08
        end
        else if (reg_wr && reg_addr == PDRS_ADDR_PWR)
        begin
            state_next.pwr = reg_wdata & PDRS_PWR_WMASK;
            if (reg_wdata[PDRS_BIT_SOFT_RST])
            begin
                // launch the four-cycle ctrl_rst_n sequence; the external pin does not start it
                state_next.srst_cnt = 3'(PDRS_SRST_CYCLES); // see RULE_07
                state_next.pwr = PDRS_PWR_RESET; // see RULE_08
            end
        end
        if (reg_rd)
        begin
            unique case (reg_addr)
                PDRS_ADDR_PWR:
                begin
                    state_next.rdata = state_reg.pwr & PDRS_PWR_WMASK;
                    state_next.hit = 1'b1;
                end
                PDRS_ADDR_IRQ:
                begin
                    // upper bits stay zero
                    state_next.rdata = {5'h00, state_reg.irq}; // see RULE_12
                    state_next.hit = 1'b1;
                end
                default:
                begin
                    state_next.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata = state_reg.rdata;
    assign reg_hit = state_reg.hit;
    assign ctrl_rst_n = ~srst_active;

    // =========================================================
    // run enables: global bit gates every block
    assign all_blocks_run = state_reg.pwr[PDRS_BIT_ALL]; // see RULE_06
    assign rate_conv_run = all_blocks_run
        && state_reg.pwr[PDRS_BIT_RATE_CONV]; // see RULE_01
    assign receiver_run = all_blocks_run
        && state_reg.pwr[PDRS_BIT_RECEIVER]; // see RULE_02
    assign transmitter_run = all_blocks_run
        && state_reg.pwr[PDRS_BIT_TRANSMITTER]; // see RULE_03
    assign serial_port_b_run = all_blocks_run
        && state_reg.pwr[PDRS_BIT_PORT_B]; // see RULE_04
    assign serial_port_a_run = all_blocks_run
        && state_reg.pwr[PDRS_BIT_PORT_A]; // see RULE_05

    // =========================================================
    // output gating; one register of delay keeps outputs glitch free
    pdrs_gate #(.WIDTH(RX_OUT_W)) i_pdrs_gate_rx (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(receiver_run), // see RULE_02
        .din(receiver_raw),
        .dout(receiver_out)
    );
    pdrs_gate #(.WIDTH(TX_OUT_W)) i_pdrs_gate_tx (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(transmitter_run), // see RULE_03
        .din(transmitter_raw),
        .dout(transmitter_out)
    );
    pdrs_gate #(.WIDTH(PA_OUT_W)) i_pdrs_gate_pa (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(serial_port_a_run), // see RULE_05
        .din(serial_port_a_raw),
        .dout(serial_port_a_out)
    );
    pdrs_gate #(.WIDTH(PB_OUT_W)) i_pdrs_gate_pb (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(serial_port_b_run), // see RULE_04
        .din(serial_port_b_raw),
        .dout(serial_port_b_out)
    );

    // =========================================================
    // checks
    chk_global_gates_all: assert property (@(posedge clk_sys) // see RULE_06
        disable iff (!rst_n)
        !all_blocks_run |-> !(rate_conv_run || receiver_run
            || transmitter_run || serial_port_a_run || serial_port_b_run))
        else $error("block runs while global power-down active");

    chk_rc_follows_bit: assert property (@(posedge clk_sys) // see RULE_01
        disable iff (!rst_n)
        !state_reg.pwr[PDRS_BIT_RATE_CONV] |-> !rate_conv_run)
        else $error("rate converter runs with its bit clear");

    chk_rx_out_low: assert property (@(posedge clk_sys) // see RULE_02
        disable iff (!rst_n)
        !receiver_run ##1 $stable(receiver_run) |-> receiver_out == '0)
        else $error("receiver output not low while powered down");

    chk_tx_out_low: assert property (@(posedge clk_sys) // see RULE_03
        disable iff (!rst_n)
        !transmitter_run ##1 !transmitter_run |-> transmitter_out == '0)
        else $error("transmitter output not low while powered down");

    chk_pb_out_low: assert property (@(posedge clk_sys) // see RULE_04
        disable iff (!rst_n)
        !serial_port_b_run |=> serial_port_b_out == '0)
        else $error("port b output not low while powered down");

    chk_pa_out_pass: assert property (@(posedge clk_sys) // see RULE_05
        disable iff (!rst_n)
        serial_port_a_run |=> serial_port_a_out == $past(serial_port_a_raw))
        else $error("port a output does not follow source");

    chk_srst_seq: assert property (@(posedge clk_sys) // see RULE_07
        disable iff (!rst_n)
        (reg_wr && reg_addr == PDRS_ADDR_PWR
            && reg_wdata[PDRS_BIT_SOFT_RST] && !srst_active)
        |=> !ctrl_rst_n [*4] ##1 ctrl_rst_n)
        else $error("soft reset sequence has wrong length");

    chk_srst_default: assert property (@(posedge clk_sys) // see RULE_08
        disable iff (!rst_n)
        srst_active |=> state_reg.pwr == PDRS_PWR_RESET)
        else $error("registers not at default during soft reset");

    chk_irq_rc: assert property (@(posedge clk_sys) // see RULE_09
        disable iff (!rst_n)
        |rate_conv_irq_src |=> state_reg.irq[PDRS_IRQ_RATE_CONV])
        else $error("rate converter summary bit missing");

    chk_irq_rx: assert property (@(posedge clk_sys) // see RULE_10
        disable iff (!rst_n)
        ##1 state_reg.irq[PDRS_IRQ_RECEIVER]
            == (|$past(receiver_irq_src)))
        else $error("receiver summary bit wrong");

    chk_irq_tx: assert property (@(posedge clk_sys) // see RULE_11
        disable iff (!rst_n)
        ##1 state_reg.irq[PDRS_IRQ_TRANSMITTER]
            == (|$past(transmitter_irq_src)))
        else $error("transmitter summary bit wrong");

    chk_irq_read_zero: assert property (@(posedge clk_sys) // see RULE_12
        disable iff (!rst_n)
        (reg_rd && reg_addr == PDRS_ADDR_IRQ)
        |=> reg_hit && reg_rdata[7:3] == 5'h00)
        else $error("summary upper bits not zero");

    cov_soft_reset: cover property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(ctrl_rst_n));
    cov_all_run: cover property (@(posedge clk_sys) disable iff (!rst_n)
        rate_conv_run && receiver_run && transmitter_run);
    cov_irq_all: cover property (@(posedge clk_sys) disable iff (!rst_n)
        state_reg.irq == 3'h7);

endmodule : pdrs_ctrl

//--- src/pdrs_pkg.sv
package pdrs_pkg;

    // =========================================================
    // register map
    localparam logic [6:0] PDRS_ADDR_PWR = 7'h01;
    localparam logic [6:0] PDRS_ADDR_IRQ = 7'h02;
    localparam logic [6:0] PDRS_ADDR_RC_STAT = 7'h0A;
    localparam logic [6:0] PDRS_ADDR_RX_STAT0 = 7'h14;
    localparam logic [6:0] PDRS_ADDR_RX_STAT1 = 7'h15;

    // =========================================================
    // power-down register fields
    localparam int PDRS_BIT_RATE_CONV = 0;
    localparam int PDRS_BIT_RECEIVER = 1;
    localparam int PDRS_BIT_TRANSMITTER = 2;
    localparam int PDRS_BIT_PORT_B = 3;
    localparam int PDRS_BIT_PORT_A = 4;
    localparam int PDRS_BIT_ALL = 5;
    localparam int PDRS_BIT_SOFT_RST = 7;
    localparam logic [7:0] PDRS_PWR_RESET = 8'h00;
    localparam logic [7:0] PDRS_PWR_WMASK = 8'hBF;

    // =========================================================
    // summary register fields
    localparam int PDRS_IRQ_RATE_CONV = 0;
    localparam int PDRS_IRQ_RECEIVER = 1;
    localparam int PDRS_IRQ_TRANSMITTER = 2;
    localparam int PDRS_IRQ_NBITS = 3;

    // =========================================================
    // widths and timing
    localparam int PDRS_RX_SRC_W = 9;
    localparam int PDRS_TX_SRC_W = 2;
    localparam int PDRS_RC_SRC_W = 2;
    localparam int PDRS_SRST_CYCLES = 4;

endpackage : pdrs_pkg

//--- src/pdrs_gate.sv
`timescale 1ns/1ns
// forces a function block's outputs low while it is powered down
module pdrs_gate
    import pdrs_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // control
    input wire logic run,
    // data
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    // a zero-width gate has nothing to force low
    if (WIDTH < 1)
    begin : g_bad_width
        $error("pdrs_gate: WIDTH must be at least 1");
    end

    typedef struct packed {
        logic [WIDTH-1:0] q;
    } pdrs_gate_s;

    pdrs_gate_s state_reg;
    pdrs_gate_s state_next;

    // =========================================================
    // output gating: powered-down block reads as all zeros
    always_comb
    begin
        state_next = state_reg;
        state_next.q = run ? din : '0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign dout = state_reg.q;

endmodule : pdrs_gate

//--- dv/pdrs_ctrl_test.sv
`timescale 1ns/1ns
// =========================================================
// self-checking bench for the power-down and summary block
`define CHK(name, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("ERROR %s expected %h seen %h", name, exp, got); \
        end \
    end
module pdrs_ctrl_test;
    import pdrs_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [6:0] reg_addr = 7'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic reg_hit;
    logic [1:0] rc_src = 2'h0;
    logic [8:0] rx_src = 9'h000;
    logic [1:0] tx_src = 2'h0;
    logic rc_run, rx_run, tx_run, pa_run, pb_run, all_run, ctrl_rst_n;
    logic [7:0] rx_raw = 8'h00;
    logic [3:0] tx_raw = 4'h0;
    logic [2:0] pa_raw = 3'h0;
    logic [2:0] pb_raw = 3'h0;
    logic [7:0] rx_out;
    logic [3:0] tx_out;
    logic [2:0] pa_out, pb_out;
    logic [5:0] runs;
    int n_mismatch = 0;
    int comparisons = 0;

    pdrs_ctrl i_pdrs_ctrl (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
        .rate_conv_irq_src(rc_src), .receiver_irq_src(rx_src),
        .transmitter_irq_src(tx_src), .rate_conv_run(rc_run),
        .receiver_run(rx_run), .transmitter_run(tx_run),
        .serial_port_a_run(pa_run), .serial_port_b_run(pb_run),
        .all_blocks_run(all_run), .ctrl_rst_n(ctrl_rst_n),
        .receiver_raw(rx_raw), .transmitter_raw(tx_raw),
        .serial_port_a_raw(pa_raw), .serial_port_b_raw(pb_raw),
        .receiver_out(rx_out), .transmitter_out(tx_out),
        .serial_port_a_out(pa_out), .serial_port_b_out(pb_out));

    // all run levels in one word, global bit on top
    assign runs = {all_run, pa_run, pb_run, tx_run, rx_run, rc_run};

    // free-running 100 MHz clock
    always #5 clk_sys = ~clk_sys;

    // =========================================================
    // bus tasks; strobes move only at falling edges
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask : wr

    // read data is registered, so it is sampled one edge after the take
    task automatic rd(input logic [6:0] a, output logic [7:0] d,
                      output logic h);
        @(negedge clk_sys);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        d = reg_rdata;
        h = reg_hit;
    endtask : rd

    // =========================================================
    // scenarios
    task automatic t_reset_values;
        logic [7:0] d;
        logic h;
        rd(PDRS_ADDR_PWR, d, h);
        `CHK("pwr after reset", 8'h00, d)
        `CHK("pwr hit", 1'b1, h)
        `CHK("runs after reset", 6'h00, runs)
        `CHK("ctrl reset idle", 1'b1, ctrl_rst_n)
    endtask : t_reset_values

    task automatic t_run_bits;
        logic [7:0] v;
        logic [7:0] d;
        logic h;
        for (int i = 0; i < 5; i++)
        begin
            for (int g = 0; g < 2; g++)
            begin
                v = (8'h01 << i) | (g ? 8'h20 : 8'h00);
                wr(PDRS_ADDR_PWR, v);
                // each block needs the global bit as well
                `CHK("rc run", v[0] & v[5], rc_run)
                `CHK("rx run", v[1] & v[5], rx_run)
                `CHK("tx run", v[2] & v[5], tx_run)
                `CHK("pb run", v[3] & v[5], pb_run)
                `CHK("pa run", v[4] & v[5], pa_run)
                `CHK("all run", v[5], all_run)
            end
        end
        // bit 6 is not stored and reads as zero
        wr(PDRS_ADDR_PWR, 8'h7F);
        rd(PDRS_ADDR_PWR, d, h);
        `CHK("pwr readback", 8'h3F, d)
    endtask : t_run_bits

    task automatic t_gating;
        wr(PDRS_ADDR_PWR, 8'h3F);
        rx_raw = 8'hA5;
        tx_raw = 4'h9;
        pa_raw = 3'h5;
        pb_raw = 3'h6;
        @(negedge clk_sys);
        `CHK("rx out on", 8'hA5, rx_out)
        `CHK("tx out on", 4'h9, tx_out)
        `CHK("pb out on", 3'h6, pb_out)
        `CHK("pa out on", 3'h5, pa_out)
        wr(PDRS_ADDR_PWR, 8'h2A);
        @(negedge clk_sys);
        `CHK("rx out kept", 8'hA5, rx_out)
        `CHK("tx out low", 4'h0, tx_out)
        `CHK("pb out kept", 3'h6, pb_out)
        `CHK("pa out low", 3'h0, pa_out)
        wr(PDRS_ADDR_PWR, 8'h1F);
        @(negedge clk_sys);
        `CHK("rx out off", 8'h00, rx_out)
        `CHK("tx out off", 4'h0, tx_out)
        `CHK("pa out off", 3'h0, pa_out)
        `CHK("pb out off", 3'h0, pb_out)
    endtask : t_gating

    task automatic t_soft_reset;
        int cnt;
        logic [7:0] d;
        logic h;
        wr(PDRS_ADDR_PWR, 8'h3F);
        wr(PDRS_ADDR_PWR, 8'hBF);
        cnt = 0;
        // bounded so a stuck reset cannot hang the run
        while (ctrl_rst_n === 1'b0 && cnt < 10)
        begin
            `CHK("runs in soft reset", 6'h00, runs)
            cnt++;
            @(negedge clk_sys);
        end
        `CHK("soft reset length", PDRS_SRST_CYCLES, cnt)
        rd(PDRS_ADDR_PWR, d, h);
        `CHK("pwr after soft reset", 8'h00, d)
        // the pin reset in mid-run must leave the same defaults
        wr(PDRS_ADDR_PWR, 8'h3F);
        @(negedge clk_sys);
        rst_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        rd(PDRS_ADDR_PWR, d, h);
        `CHK("pwr after pin reset", 8'h00, d)
        `CHK("runs after pin reset", 6'h00, runs)
        `CHK("rx out after pin reset", 8'h00, rx_out)
    endtask : t_soft_reset

    task automatic t_summary;
        logic [7:0] d;
        logic [7:0] e;
        logic h;
        for (int i = 0; i < 4; i++)
        begin
            @(negedge clk_sys);
            rc_src = (i == 0 || i == 3) ? 2'h2 : 2'h0;
            rx_src = (i == 1 || i == 3) ? 9'h100 : 9'h000;
            tx_src = (i == 2 || i == 3) ? 2'h1 : 2'h0;
            rd(PDRS_ADDR_IRQ, d, h);
            e = (i == 3) ? 8'h07 : (8'h01 << i);
            `CHK("summary", e, d)
            `CHK("summary hit", 1'b1, h)
        end
        @(negedge clk_sys);
        {rc_src, rx_src, tx_src} = 13'h0000;
        wr(PDRS_ADDR_IRQ, 8'hFF);
        rd(PDRS_ADDR_IRQ, d, h);
        `CHK("summary read-only", 8'h00, d)
        rd(7'h03, d, h);
        `CHK("unmapped data", 8'h00, d)
        `CHK("unmapped hit", 1'b0, h)
    endtask : t_summary

    // =========================================================
    // verdict and hang guard
    task automatic end_of_test;
        if (n_mismatch == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    // the sequence needs well under 1000 cycles
    initial
    begin
        #100000;
        n_mismatch++;
        end_of_test();
    end

    initial
    begin
        repeat (5) @(negedge clk_sys);
        rst_n = 1'b1;
        t_reset_values();
        t_run_bits();
        t_gating();
        t_soft_reset();
        t_summary();
        end_of_test();
    end
endmodule : pdrs_ctrl_test
